// ---- rtl/io_command_execution_sequencer.sv ----
// Execute-I/O sequencer with priority interrupt entry and register slave
//
// Function
// - Code 010 reads one word from the unit into storage at the address word.
// - Code 101 starts a channel write; data then fetched by the channel.
// - Code 110 starts a channel read; data then delivered by the channel.
// - Command effective address must be even; address word even, control word odd.
// - First cycle forces low address bit, reads control word, drives it out.
// - Initialize: second cycle loads channel address register, checks it, ends.
// - Direct read/write: second cycle loads accumulator with the address word.
// - Direct read/write: third cycle uses accumulator address, moves one word, ends.
// - Control: adapters decode in first cycle, act in second; no third.
// - Sense interrupt drives modifier bits 10 to 15 onto the out-bus.
// - Sense interrupt: level status word via buffer into accumulator; no third.
// - Device status word goes from in-bus via buffer into accumulator.
// - Twelve standard interrupt levels, extendable by twelve in groups of six.
// - Active level branches only after the current instruction completes.
// - Entry stores next address via table entry and continues one above.
// - Each interrupt level is maskable and unmaskable by program.
// - Branch word with bit 9 set restores the interrupt logic.
// - Control word holds five-bit area, three-bit function and modifier.
// - Code 001 writes one word from storage at the address word to the unit.
`timescale 1ns/10ps
module io_command_execution_sequencer #(
   parameter int LEVELS = io_seq_pkg::STD_LEVELS
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic mem_req,
   output logic mem_we,
   output logic [15:0] mem_addr,
   output logic [15:0] mem_wdata,
   input wire logic [15:0] mem_rdata,
   input wire logic mem_ack,
   output io_seq_pkg::out_bus_s out_bus,
   input wire logic [15:0] in_bus,
   input wire logic adapter_resp,
   input wire logic car_load_ok,
   input wire logic [23:0] int_request,
   output logic [23:0] levels_in_service
);
   localparam logic [23:0] LEVEL_EN = 24'((25'h1 << LEVELS) - 25'h1);

   io_seq_pkg::seq_s st;
   io_seq_pkg::seq_s next_st;
   logic [2:0] func;
   logic [23:0] pending;
   logic [5:0] pick;
   logic int_go;
   logic req;
   logic cmd_blk;
   logic accept;
   logic bus_done;
   logic [31:0] rd_mux;

   // Highest-priority pending level above every level in service
   function automatic logic [5:0] pick_level(input logic [23:0] pend, input logic [23:0] ins);
      logic seen;
      logic [5:0] r;
      seen = 1'b0;
      r = 6'h00;
      for (int i = 0; i < io_seq_pkg::MAX_LEVELS; i++)
      begin
         seen = seen | ins[i];
         if (pend[i] && !seen && !r[5])
         begin
            r = {1'b1, 5'(i)};
         end
      end
      return r;
   endfunction

   // Releases the highest-priority level in service
   function automatic logic [23:0] release_top(input logic [23:0] ins);
      logic [23:0] r;
      logic done;
      r = ins;
      done = 1'b0;
      for (int i = 0; i < io_seq_pkg::MAX_LEVELS; i++)
      begin
         if (r[i] && !done)
         begin
            r[i] = 1'b0;
            done = 1'b1;
         end
      end
      return r;
   endfunction

   assign func = st.cw[io_seq_pkg::FUNC_LSB +: 3];
   assign pending = st.irq_s2 & ~st.mask & LEVEL_EN;
   assign pick = pick_level(pending, st.in_service);
   assign int_go = (st.state == io_seq_pkg::S_IDLE) && pick[5];

   assign req = avs_read | avs_write;
   // Command writes wait until the sequencer is free
   assign cmd_blk = avs_write && (avs_address == io_seq_pkg::REG_COMMAND)
                    && ((st.state != io_seq_pkg::S_IDLE) || int_go);
   assign avs_waitrequest = req & (~st.bus_ack | cmd_blk);
   assign accept = req & st.bus_ack & ~cmd_blk;
   assign avs_readdata = st.readdata;

   assign mem_req = (st.state == io_seq_pkg::S_CW_FETCH) || (st.state == io_seq_pkg::S_AW_FETCH)
                    || (st.state == io_seq_pkg::S_E3_FETCH) || (st.state == io_seq_pkg::S_E3_STORE)
                    || (st.state == io_seq_pkg::S_INT_TABLE) || (st.state == io_seq_pkg::S_INT_STORE);
   assign mem_we = st.mem_we;
   assign mem_addr = st.mar;
   assign mem_wdata = st.buffer;
   assign out_bus = st.obus;
   assign levels_in_service = st.in_service;
   assign bus_done = st.obus.strobe && st.resp_s2;

   always_comb
   begin
      rd_mux = 32'h0;
      unique case (avs_address)
         io_seq_pkg::REG_COMMAND: rd_mux = {16'h0, st.effective_address};
         io_seq_pkg::REG_STATUS: rd_mux = {24'h0, st.level, st.car_err, st.odd_err,
                                           st.state != io_seq_pkg::S_IDLE};
         io_seq_pkg::REG_ACCUM: rd_mux = {16'h0, st.acc};
         io_seq_pkg::REG_MASK: rd_mux = {8'h0, st.mask};
         io_seq_pkg::REG_LEVELS: rd_mux = {8'h0, pending};
         io_seq_pkg::REG_NEXT_ADDR: rd_mux = {16'h0, st.next_addr};
         default: rd_mux = 32'h0;
      endcase
   end

   always_comb
   begin
      next_st = st;
      // Pin inputs pass two flip-flops
      next_st.in_s1 = in_bus;
      next_st.in_s2 = st.in_s1;
      next_st.resp_s1 = adapter_resp;
      next_st.resp_s2 = st.resp_s1;
      next_st.carok_s1 = car_load_ok;
      next_st.carok_s2 = st.carok_s1;
      next_st.irq_s1 = int_request;
      next_st.irq_s2 = st.irq_s1;

      next_st.bus_ack = req && !st.bus_ack && !cmd_blk;
      if (req && !st.bus_ack && !cmd_blk)
      begin
         next_st.readdata = rd_mux;
      end
      if (accept && avs_write)
      begin
         unique case (avs_address)
            io_seq_pkg::REG_COMMAND:
            begin
               next_st.effective_address = avs_writedata[15:0];
               if (avs_writedata[0])
               begin
                  next_st.odd_err = 1'b1;
               end
               else
               begin
                  // force low address bit for control word
                  next_st.mar = {avs_writedata[15:1], 1'b1};
                  next_st.mem_we = 1'b0;
                  next_st.state = io_seq_pkg::S_CW_FETCH;
               end
            end
            io_seq_pkg::REG_STATUS:
            begin
               if (avs_writedata[io_seq_pkg::ST_ODD_ERR])
               begin
                  next_st.odd_err = 1'b0;
               end
               if (avs_writedata[io_seq_pkg::ST_CAR_ERR])
               begin
                  next_st.car_err = 1'b0;
               end
            end
            io_seq_pkg::REG_ACCUM: next_st.acc = avs_writedata[15:0];
            io_seq_pkg::REG_MASK: next_st.mask = avs_writedata[23:0];
            io_seq_pkg::REG_RETURN:
            begin
               if (avs_writedata[io_seq_pkg::RETURN_BIT])
               begin
                  next_st.in_service = release_top(st.in_service);
               end
            end
            io_seq_pkg::REG_NEXT_ADDR: next_st.next_addr = avs_writedata[15:0];
            default:
            begin
            end
         endcase
      end

      // Four-phase interlock: raise strobe once response is low
      if (!st.obus.strobe && !st.resp_s2 && (st.state == io_seq_pkg::S_CW_BUS
          || st.state == io_seq_pkg::S_E2_BUS || st.state == io_seq_pkg::S_E3_BUS))
      begin
         next_st.obus.strobe = 1'b1;
      end
      if (bus_done)
      begin
         next_st.obus.strobe = 1'b0;
      end

      unique case (st.state)
         io_seq_pkg::S_IDLE:
         begin
            // forced branch reads table entry of the level
            if (int_go)
            begin
               next_st.level = pick[4:0];
               next_st.mar = io_seq_pkg::INT_TABLE_BASE + {11'h0, pick[4:0]};
               next_st.mem_we = 1'b0;
               next_st.state = io_seq_pkg::S_INT_TABLE;
            end
         end
         io_seq_pkg::S_CW_FETCH:
         begin
            if (mem_ack)
            begin
               next_st.cw = mem_rdata;
               next_st.obus.data = mem_rdata;
               next_st.obus.cycle = io_seq_pkg::control_word_cycle;
               next_st.state = io_seq_pkg::S_CW_BUS;
            end
         end
         io_seq_pkg::S_CW_BUS:
         begin
            if (bus_done)
            begin
               if (func == io_seq_pkg::FN_SENSE_INT || func == io_seq_pkg::FN_SENSE_DEV)
               begin
                  // level select on modifier bits 10 to 15
                  next_st.obus.data = (func == io_seq_pkg::FN_SENSE_INT)
                                      ? {10'h0, st.cw[io_seq_pkg::SENSE_LEVEL_W-1:0]} : st.cw;
                  next_st.obus.cycle = io_seq_pkg::second_execution_cycle;
                  next_st.state = io_seq_pkg::S_E2_BUS;
               end
               else
               begin
                  next_st.mar = st.effective_address;
                  next_st.state = io_seq_pkg::S_AW_FETCH;
               end
            end
         end
         io_seq_pkg::S_AW_FETCH:
         begin
            if (mem_ack)
            begin
               if (func == io_seq_pkg::FN_READ || func == io_seq_pkg::FN_WRITE)
               begin
                  next_st.acc = mem_rdata;
                  next_st.state = io_seq_pkg::S_E3_ADDR;
               end
               else
               begin
                  // address word on out-bus in second cycle
                  next_st.obus.data = mem_rdata;
                  next_st.obus.cycle = io_seq_pkg::second_execution_cycle;
                  next_st.obus.car_load = (func == io_seq_pkg::FN_INIT_WRITE)
                                          || (func == io_seq_pkg::FN_INIT_READ);
                  next_st.state = io_seq_pkg::S_E2_BUS;
               end
            end
         end
         io_seq_pkg::S_E2_BUS:
         begin
            if (bus_done)
            begin
               next_st.state = io_seq_pkg::S_RELEASE;
               if (st.obus.car_load && !st.carok_s2)
               begin
                  next_st.car_err = 1'b1;
               end
               if (func == io_seq_pkg::FN_SENSE_INT || func == io_seq_pkg::FN_SENSE_DEV)
               begin
                  next_st.buffer = st.in_s2;
                  next_st.state = io_seq_pkg::S_SENSE_ACC;
               end
            end
         end
         io_seq_pkg::S_SENSE_ACC:
         begin
            next_st.acc = st.buffer;
            next_st.state = io_seq_pkg::S_RELEASE;
         end
         io_seq_pkg::S_E3_ADDR:
         begin
            next_st.mar = st.acc;
            next_st.obus.cycle = io_seq_pkg::third_execution_cycle;
            if (func == io_seq_pkg::FN_WRITE)
            begin
               next_st.state = io_seq_pkg::S_E3_FETCH;
            end
            else
            begin
               next_st.obus.data = 16'h0000;
               next_st.state = io_seq_pkg::S_E3_BUS;
            end
         end
         io_seq_pkg::S_E3_FETCH:
         begin
            if (mem_ack)
            begin
               next_st.buffer = mem_rdata;
               next_st.obus.data = mem_rdata;
               next_st.state = io_seq_pkg::S_E3_BUS;
            end
         end
         io_seq_pkg::S_E3_BUS:
         begin
            if (bus_done)
            begin
               next_st.state = io_seq_pkg::S_RELEASE;
               if (func == io_seq_pkg::FN_READ)
               begin
                  next_st.buffer = st.in_s2;
                  next_st.mem_we = 1'b1;
                  next_st.state = io_seq_pkg::S_E3_STORE;
               end
            end
         end
         io_seq_pkg::S_E3_STORE:
         begin
            if (mem_ack)
            begin
               next_st.mem_we = 1'b0;
               next_st.state = io_seq_pkg::S_RELEASE;
            end
         end
         io_seq_pkg::S_RELEASE:
         begin
            next_st.obus.car_load = 1'b0;
            next_st.obus.cycle = io_seq_pkg::cycle_idle;
            if (!st.resp_s2)
            begin
               next_st.state = io_seq_pkg::S_IDLE;
            end
         end
         io_seq_pkg::S_INT_TABLE:
         begin
            if (mem_ack)
            begin
               next_st.effective_address = mem_rdata;
               next_st.mar = mem_rdata;
               next_st.buffer = st.next_addr;
               next_st.mem_we = 1'b1;
               next_st.state = io_seq_pkg::S_INT_STORE;
            end
         end
         io_seq_pkg::S_INT_STORE:
         begin
            if (mem_ack)
            begin
               next_st.mem_we = 1'b0;
               next_st.next_addr = st.effective_address + 16'h0001;
               next_st.in_service[st.level] = 1'b1;
               next_st.state = io_seq_pkg::S_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         st <= '0;
         st.mask <= io_seq_pkg::MASK_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end
endmodule

// ---- inc/io_seq_pkg.sv ----
// Shared constants and types for the execute-I/O sequencer
package io_seq_pkg;
   // Register offsets, byte addresses on the slave port
   localparam logic [4:0] REG_COMMAND = 5'h00;
   localparam logic [4:0] REG_STATUS = 5'h04;
   localparam logic [4:0] REG_ACCUM = 5'h08;
   localparam logic [4:0] REG_MASK = 5'h0C;
   localparam logic [4:0] REG_LEVELS = 5'h10;
   localparam logic [4:0] REG_RETURN = 5'h14;
   localparam logic [4:0] REG_NEXT_ADDR = 5'h18;

   // Control word fields; bit 0 of the word as printed is the MSB here
   localparam int AREA_LSB = 11;
   localparam int FUNC_LSB = 8;
   localparam int MOD15_BIT = 0;
   localparam int SENSE_LEVEL_W = 6;
   // Instruction bit 9 of a branch word, counted from the MSB
   localparam int RETURN_BIT = 6;
   // Status register bits
   localparam int ST_BUSY = 0;
   localparam int ST_ODD_ERR = 1;
   localparam int ST_CAR_ERR = 2;

   // Function codes of the control word
   localparam logic [2:0] FN_DIAG = 3'h0;
   localparam logic [2:0] FN_WRITE = 3'h1;
   localparam logic [2:0] FN_READ = 3'h2;
   localparam logic [2:0] FN_SENSE_INT = 3'h3;
   localparam logic [2:0] FN_CONTROL = 3'h4;
   localparam logic [2:0] FN_INIT_WRITE = 3'h5;
   localparam logic [2:0] FN_INIT_READ = 3'h6;
   localparam logic [2:0] FN_SENSE_DEV = 3'h7;

   // Reset values and interrupt layout
   localparam logic [23:0] MASK_RESET = 24'hFFFFFF;
   localparam logic [15:0] INT_TABLE_BASE = 16'h000B;
   localparam int MAX_LEVELS = 24;
   localparam int STD_LEVELS = 12;

   typedef enum logic [1:0] {
      cycle_idle,
      control_word_cycle,
      second_execution_cycle,
      third_execution_cycle
   } xio_cycle_e;

   typedef enum logic [3:0] {
      S_IDLE,
      S_CW_FETCH,
      S_CW_BUS,
      S_AW_FETCH,
      S_E2_BUS,
      S_SENSE_ACC,
      S_E3_ADDR,
      S_E3_FETCH,
      S_E3_BUS,
      S_E3_STORE,
      S_RELEASE,
      S_INT_TABLE,
      S_INT_STORE
   } seq_state_e;

   // Out-bus group seen by every adapter
   typedef struct packed {
      logic [15:0] data;
      logic strobe;
      xio_cycle_e cycle;
      logic car_load;
   } out_bus_s;

   typedef struct packed {
      seq_state_e state;
      logic [15:0] effective_address;
      logic [15:0] cw;
      logic [15:0] acc;
      logic [15:0] buffer;
      logic [15:0] mar;
      logic [15:0] next_addr;
      logic mem_we;
      out_bus_s obus;
      logic [23:0] mask;
      logic [23:0] in_service;
      logic [4:0] level;
      logic odd_err;
      logic car_err;
      logic bus_ack;
      logic [31:0] readdata;
      logic [15:0] in_s1;
      logic [15:0] in_s2;
      logic resp_s1;
      logic resp_s2;
      logic carok_s1;
      logic carok_s2;
      logic [23:0] irq_s1;
      logic [23:0] irq_s2;
   } seq_s;
endpackage

// ---- test/io_seq_chk.sv ----
// Assertion checker on the execute-I/O sequencer ports
`timescale 1ns/10ps
module io_seq_chk #(
   parameter int LEVELS = 12
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic avs_read,
   input wire logic avs_waitrequest,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [15:0] mem_addr,
   input wire logic mem_ack,
   input wire io_seq_pkg::out_bus_s out_bus,
   input wire logic adapter_resp,
   input wire logic [23:0] levels_in_service
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   logic [2:0] func;
   logic [5:0] modf;
   // Remember the decoded control word of the running instruction
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         func <= 3'h0;
         modf <= 6'h00;
      end
      else if (out_bus.strobe && out_bus.cycle == io_seq_pkg::control_word_cycle)
      begin
         func <= out_bus.data[10:8];
         modf <= out_bus.data[5:0];
      end
   end
   AST_MEM_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
      else $error("memory request dropped or changed before ack");
   AST_STROBE_WAIT: assert property (out_bus.strobe && !adapter_resp |=> out_bus.strobe)
      else $error("strobe fell before adapter answered");
   AST_STROBE_DROP: assert property ($rose(adapter_resp) && out_bus.strobe |-> ##[1:4] !out_bus.strobe)
      else $error("strobe not released after answer");
   AST_CAR_CYCLE: assert property (out_bus.car_load |-> out_bus.cycle == io_seq_pkg::second_execution_cycle)
      else $error("channel load outside second cycle");
   AST_SENSE_MOD: assert property (out_bus.strobe && out_bus.cycle == io_seq_pkg::second_execution_cycle
      && func == io_seq_pkg::FN_SENSE_INT |-> out_bus.data[5:0] == modf)
      else $error("sense level bits not on out-bus");
   AST_NO_THIRD: assert property (out_bus.cycle == io_seq_pkg::third_execution_cycle
      |-> func == io_seq_pkg::FN_WRITE || func == io_seq_pkg::FN_READ)
      else $error("third cycle for a function without data word");
   AST_AVS_ANSWER: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("register read not answered in one cycle");
   AST_ENTRY_IDLE: assert property ((levels_in_service & ~$past(levels_in_service)) != 24'h000000
      |-> out_bus.cycle == io_seq_pkg::cycle_idle && !out_bus.strobe)
      else $error("interrupt entered during an instruction");
   AST_LEVEL_RANGE: assert property ((levels_in_service >> LEVELS) == 24'h000000)
      else $error("level beyond configured count in service");
   cover property (out_bus.strobe && out_bus.cycle == io_seq_pkg::third_execution_cycle);
   cover property (out_bus.car_load && out_bus.strobe);
   cover property ($rose(|levels_in_service));
endmodule
bind io_command_execution_sequencer io_seq_chk #(.LEVELS(LEVELS)) chk_inst (.clock(clock), .sys_rst(sys_rst),
   .avs_read(avs_read), .avs_waitrequest(avs_waitrequest), .mem_req(mem_req), .mem_we(mem_we),
   .mem_addr(mem_addr), .mem_ack(mem_ack), .out_bus(out_bus), .adapter_resp(adapter_resp),
   .levels_in_service(levels_in_service));

// ---- test/io_partner.sv ----
// Core storage and adapter model on the far side of the sequencer
`timescale 1ns/10ps
module io_partner (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [15:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   output logic [15:0] mem_rdata,
   output logic mem_ack,
   input wire io_seq_pkg::out_bus_s out_bus,
   output logic [15:0] in_bus,
   output logic adapter_resp,
   output logic car_load_ok,
   input wire logic [15:0] dev_word,
   input wire logic car_ok
);
   logic [15:0] mem [0:65535];
   logic [15:0] got_cw, got_aw, got_word;
   logic [1:0] lat, rlat;
   int thirds = 0;
   int clears = 0;
   logic diag = 1'b0;
   always @(posedge clock)
   begin
      if (sys_rst)
      begin
         mem_ack <= 1'b0;
         mem_rdata <= 16'h5A5A;
         adapter_resp <= 1'b0;
         in_bus <= 16'hA5A5;
         car_load_ok <= 1'b0;
         lat <= 2'h0;
         rlat <= 2'h2;
      end
      else
      begin
         if (mem_ack)
         begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
         end
         else if (mem_req && lat != 2'h0)
            lat <= lat - 2'h1;
         else if (mem_req)
         begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr];
            if (mem_we)
               mem[mem_addr] <= mem_wdata;
            lat <= {~lat[1], 1'b0};
         end
         // status word held on in-bus while answering
         if (out_bus.strobe && !adapter_resp && rlat != 2'h0)
            rlat <= rlat - 2'h1;
         else if (out_bus.strobe && !adapter_resp)
         begin
            adapter_resp <= 1'b1;
            in_bus <= dev_word;
            car_load_ok <= car_ok;
            rlat <= 2'h3 - rlat;
            // adapter decodes what the out-bus carries
            case (out_bus.cycle)
               io_seq_pkg::control_word_cycle: got_cw <= out_bus.data;
               io_seq_pkg::second_execution_cycle: got_aw <= out_bus.data;
               io_seq_pkg::third_execution_cycle:
               begin
                  got_word <= out_bus.data;
                  thirds <= thirds + 1;
               end
               default: got_cw <= got_cw;
            endcase
            if (out_bus.cycle == io_seq_pkg::second_execution_cycle && got_cw[10:8] == 3'h0)
               diag <= got_cw[0];
            if (out_bus.cycle == io_seq_pkg::second_execution_cycle && got_cw[10:8] == 3'h7)
               clears <= clears + got_cw[0];
         end
         else if (!out_bus.strobe && adapter_resp)
         begin
            adapter_resp <= 1'b0;
            in_bus <= ~in_bus;
            car_load_ok <= ~car_load_ok;
         end
      end
   end
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the execute-I/O sequencer
`timescale 1ns/10ps
module tb_top;
   logic clock, sys_rst, avs_read, avs_write, avs_waitrequest, mem_req, mem_we, mem_ack;
   logic adapter_resp, car_load_ok, car_ok;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q, seed;
   logic [15:0] mem_addr, mem_wdata, mem_rdata, in_bus, dev_word, ea, aw, cw, md;
   logic [23:0] int_request, levels_in_service;
   logic [2:0] fn;
   io_seq_pkg::out_bus_s out_bus;
   int err_total = 0;
   int num_checks = 0;
   int th;
   io_command_execution_sequencer #(.LEVELS(12)) io_command_execution_sequencer_inst (.clock(clock),
      .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack), .out_bus(out_bus), .in_bus(in_bus), .adapter_resp(adapter_resp),
      .car_load_ok(car_load_ok), .int_request(int_request), .levels_in_service(levels_in_service));
   io_partner io_partner_inst (.clock(clock), .sys_rst(sys_rst), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .out_bus(out_bus),
      .in_bus(in_bus), .adapter_resp(adapter_resp), .car_load_ok(car_load_ok), .dev_word(dev_word),
      .car_ok(car_ok));
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   function automatic logic has_third(input logic [2:0] f);
      return f == io_seq_pkg::FN_WRITE || f == io_seq_pkg::FN_READ;
   endfunction
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      @(posedge clock iff avs_waitrequest === 1'b0);
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic run(input logic [15:0] a, output logic [31:0] st);
      av(1'b1, io_seq_pkg::REG_COMMAND, {16'h0000, a}, st);
      for (int i = 0; i < 200; i++)
      begin
         av(1'b0, io_seq_pkg::REG_STATUS, 32'h0, st);
         if (st[io_seq_pkg::ST_BUSY] === 1'b0)
            break;
      end
      chk("busy", st[io_seq_pkg::ST_BUSY], 1'b0);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      #200000;
      err_total++;
      end_sim;
   end
   initial
   begin
      seed = 32'h71D2;
      {avs_read, avs_write, car_ok} = 3'h0;
      avs_address = 5'h00;
      avs_writedata = 32'h0;
      dev_word = 16'h0000;
      int_request = 24'h000000;
      sys_rst = 1'b1;
      repeat (20) @(posedge clock);
      sys_rst <= 1'b0;
      // all levels masked out of reset
      av(1'b0, io_seq_pkg::REG_MASK, 32'h0, q);
      chk("mask", q, {8'h00, io_seq_pkg::MASK_RESET});
      av(1'b0, 5'h1C, 32'h0, q);
      chk("unmapped", q, 32'h0);
      for (int f = 0; f < 9; f++)
      begin
         fn = (f == 8) ? io_seq_pkg::FN_INIT_READ : f[2:0];
         ea = (16'($random(seed)) & 16'h0FFE) | 16'h1000;
         aw = (16'($random(seed)) & 16'h0FFF) | 16'h4000;
         cw = {5'($random(seed)), fn, 8'($random(seed))};
         md = 16'($random(seed));
         dev_word <= 16'($random(seed));
         car_ok <= (f != 8);
         io_partner_inst.mem[ea] = aw;
         io_partner_inst.mem[ea | 16'h1] = cw;
         io_partner_inst.mem[aw] = md;
         th = io_partner_inst.thirds;
         run(ea, q);
         chk("control word", io_partner_inst.got_cw, cw);
         chk("third cycles", io_partner_inst.thirds - th, has_third(fn));
         if (fn == io_seq_pkg::FN_WRITE)
            chk("written word", io_partner_inst.got_word, md);
         else if (fn == io_seq_pkg::FN_READ)
            chk("read word", io_partner_inst.mem[aw], dev_word);
         else if (fn == io_seq_pkg::FN_SENSE_INT)
            chk("level select", io_partner_inst.got_aw[5:0], cw[5:0]);
         else if (fn != io_seq_pkg::FN_SENSE_DEV)
            chk("address word", io_partner_inst.got_aw, aw);
         if (fn == io_seq_pkg::FN_DIAG)
            chk("diag mode", io_partner_inst.diag, cw[0]);
         if (fn == io_seq_pkg::FN_SENSE_DEV)
            chk("cleared", io_partner_inst.clears, cw[0]);
         if (fn == io_seq_pkg::FN_INIT_READ || fn == io_seq_pkg::FN_INIT_WRITE)
            chk("channel check", q[io_seq_pkg::ST_CAR_ERR], f == 8);
         av(1'b0, io_seq_pkg::REG_ACCUM, 32'h0, q);
         if (has_third(fn))
            chk("accum address", q[15:0], aw);
         else if (fn == io_seq_pkg::FN_SENSE_INT || fn == io_seq_pkg::FN_SENSE_DEV)
            chk("accum status", q[15:0], dev_word);
         av(1'b1, io_seq_pkg::REG_STATUS, 32'h6, q);
         $display("test function %0d done", fn);
      end
      th = io_partner_inst.thirds;
      run(16'h1235, q);
      chk("odd address flag", q[io_seq_pkg::ST_ODD_ERR], 1'b1);
      chk("odd address idle", io_partner_inst.got_cw, cw);
      $display("test odd address done");
      av(1'b1, io_seq_pkg::REG_NEXT_ADDR, 32'h2222, q);
      io_partner_inst.mem[io_seq_pkg::INT_TABLE_BASE + 16'h2] = 16'h3000;
      int_request <= 24'h100004;
      repeat (20) @(posedge clock);
      chk("masked level", levels_in_service, 24'h0);
      av(1'b1, io_seq_pkg::REG_MASK, 32'h0, q);
      for (int i = 0; i < 100 && levels_in_service[2] !== 1'b1; i++)
         @(posedge clock);
      repeat (4) @(posedge clock);
      chk("in service", levels_in_service, 24'h000004);
      chk("stored link", io_partner_inst.mem[16'h3000], 16'h2222);
      av(1'b0, io_seq_pkg::REG_NEXT_ADDR, 32'h0, q);
      chk("entry address", q, 32'h3001);
      av(1'b0, io_seq_pkg::REG_LEVELS, 32'h0, q);
      chk("pending", q, 32'h4);
      int_request <= 24'h000000;
      av(1'b1, io_seq_pkg::REG_RETURN, 32'h40, q);
      repeat (4) @(posedge clock);
      chk("released", levels_in_service, 24'h0);
      $display("test interrupt done");
      end_sim;
   end
endmodule
